// >>> shared/sip_pkg.sv
// constants shared by the sub-clock interval prescaler and its counter core
// assumes a single system clock; sub-clock arrives as a one-cycle tick
package sip_pkg;

  // ************************************************************
  // counter geometry
  // ************************************************************
  localparam int CNT_W = 15;
  localparam logic [14:0] CNT_RESET = 15'h0000;
  localparam logic [14:0] CNT_ALL_ONES = 15'h7fff;
  // tap bits: periods 2^10, 2^13, 2^14, 2^15
  localparam logic [3:0] TAP_SEL0 = 4'h9;
  localparam logic [3:0] TAP_SEL1 = 4'hc;
  localparam logic [3:0] TAP_SEL2 = 4'hd;
  localparam logic [3:0] TAP_SEL3 = 4'he;
  localparam logic [3:0] TAP_STAB = 4'he;
  localparam logic [3:0] TAP_WDT = 4'hd;
  localparam logic [3:0] TAP_BUZ_LO = 4'h2;
  localparam logic [3:0] TAP_BUZ_HI = 4'h4;

  // ************************************************************
  // register map (byte addresses)
  // ************************************************************
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_STATUS = 4'h4;
  localparam logic [3:0] ADDR_MASK = 4'h8;
  localparam logic [3:0] ADDR_COUNT = 4'hc;

  // control register fields
  localparam int CTRL_FLAG = 7;
  localparam int CTRL_EN = 6;
  localparam int CTRL_SEL_HI = 2;
  localparam int CTRL_SEL_LO = 1;
  localparam int CTRL_CLR = 0;
  localparam logic CTRL_FLAG_RST = 1'b0;
  localparam logic CTRL_EN_RST = 1'b0;
  localparam logic [1:0] CTRL_SEL_RST = 2'h0;

  // status and mask fields
  localparam int EVT_W = 2;
  localparam int EVT_INTERVAL = 0;
  localparam int EVT_STAB_DONE = 1;
  localparam logic [1:0] STATUS_RST = 2'h0;
  localparam logic [1:0] MASK_RST = 2'h0;

  // count register: stabilization wait state above the count
  localparam int COUNT_STAB = 16;

  // tap bit index for an interval select value
  function automatic logic [3:0] sip_tap_idx(input logic [1:0] sel);
    case (sel)
      2'h0: sip_tap_idx = TAP_SEL0;
      2'h1: sip_tap_idx = TAP_SEL1;
      2'h2: sip_tap_idx = TAP_SEL2;
      default: sip_tap_idx = TAP_SEL3;
    endcase
  endfunction

endpackage

// >>> core/sip_counter.sv
// free-running 15-bit counter with tap select, falling-edge detect and
// stabilization wait timer
// assumes tick is a one-cycle pulse per sub-clock period, synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module sip_counter
  import sip_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic clear,
  input wire logic [1:0] sel,
  output logic [14:0] cnt,
  output logic tap_fall,
  output logic stab_wait
);

  logic [14:0] next_cnt;
  logic [3:0] tap;

  assign next_cnt = cnt + 15'h0001;
  assign tap = sip_tap_idx(sel);
  // qualified by clear so a coincident clear suppresses the event
  assign tap_fall = tick && !clear && cnt[tap] && !next_cnt[tap];

  // ************************************************************
  // counter
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= CNT_RESET;
    end else if (clear) begin
      cnt <= CNT_RESET;
    end else if (tick) begin
      cnt <= next_cnt;
    end
  end

  // ************************************************************
  // stabilization wait: from clear until the top bit falls
  // ************************************************************
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stab_wait <= 1'b1;
    end else if (clear) begin
      stab_wait <= 1'b1;
    end else if (tick && cnt[TAP_STAB] && !next_cnt[TAP_STAB]) begin
      stab_wait <= 1'b0;
    end
  end

  chk_count_advance: assert property (@(posedge clk) disable iff (!rst_n)
    tick && !clear |=> cnt == $past(cnt) + 15'h0001)
    else $error("counter did not advance on tick");
  chk_count_wrap: assert property (@(posedge clk) disable iff (!rst_n)
    tick && !clear && cnt == CNT_ALL_ONES |=> cnt == CNT_RESET)
    else $error("counter did not wrap to zero");
  chk_stab_end: assert property (@(posedge clk) disable iff (!rst_n)
    $fell(stab_wait) |-> cnt == CNT_RESET && !$past(clear))
    else $error("stabilization wait ended off the top-bit fall");

endmodule
`default_nettype wire

// >>> core/sip_prescaler.sv
// sub-clock interval prescaler: Avalon-MM register slave, interval event flag,
// sticky event status with mask, tap clocks for watchdog and buzzer
// assumes SUBCLK_TICK, STOP_REQUEST and POWER_ON_CLEAR are synchronous to MCLK
`timescale 1ns/1ps
`default_nettype none
module sip_prescaler
  import sip_pkg::*;
#(
  parameter bit HAS_POR = 1'b1,
  parameter bit DUAL_CLOCK = 1'b1
) (
  input wire logic MCLK,
  input wire logic RESETN,
  input wire logic SUBCLK_TICK,
  input wire logic STOP_REQUEST,
  input wire logic POWER_ON_CLEAR,
  input wire logic [3:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic INTERVAL_IRQ_LINE,
  output logic EVENT_IRQ,
  output logic STAB_WAIT,
  output logic WDT_CLK,
  output logic [2:0] BUZ_CLK
);

  // ************************************************************
  // bus slave: one wait state on every access
  // ************************************************************
  logic ack;
  logic req;
  logic rd_acc;
  logic wr_acc;
  logic lane0;

  assign req = AVS_READ || AVS_WRITE;
  assign AVS_WAITREQUEST = req && !ack;
  assign rd_acc = AVS_READ && ack;
  assign wr_acc = AVS_WRITE && ack;
  assign lane0 = AVS_BYTEENABLE[0];

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      ack <= 1'b0;
    end else begin
      ack <= req && !ack;
    end
  end

  // ************************************************************
  // control register
  // ************************************************************
  logic interval_event_flag;
  logic interval_irq_enable;
  logic interval_select_hi;
  logic interval_select_lo;
  logic ctrl_wr;
  logic sw_clr;
  logic cnt_clear;
  logic tap_fall;
  logic evt;
  logic stab_wait;
  logic [14:0] cnt;

  assign ctrl_wr = wr_acc && lane0 && AVS_ADDRESS == ADDR_CTRL;
  // writing one to the clear bit is a no-op
  assign sw_clr = ctrl_wr && !AVS_WRITEDATA[CTRL_CLR];
  // single-clock build has no sub-clock, so the counter is parked
  assign cnt_clear = sw_clr || STOP_REQUEST || (HAS_POR && POWER_ON_CLEAR)
    || !DUAL_CLOCK;
  assign evt = tap_fall && DUAL_CLOCK;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      interval_irq_enable <= CTRL_EN_RST;
      interval_select_hi <= CTRL_SEL_RST[1];
      interval_select_lo <= CTRL_SEL_RST[0];
    end else if (ctrl_wr) begin
      interval_irq_enable <= AVS_WRITEDATA[CTRL_EN];
      interval_select_hi <= AVS_WRITEDATA[CTRL_SEL_HI];
      interval_select_lo <= AVS_WRITEDATA[CTRL_SEL_LO];
    end
  end

  // set wins over a coincident zero write
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      interval_event_flag <= CTRL_FLAG_RST;
    end else if (evt) begin
      interval_event_flag <= 1'b1;
    end else if (ctrl_wr && !AVS_WRITEDATA[CTRL_FLAG]) begin
      interval_event_flag <= 1'b0;
    end
  end

  assign INTERVAL_IRQ_LINE = interval_event_flag && interval_irq_enable;

  // ************************************************************
  // counter core
  // ************************************************************
  sip_counter u_counter (
    .clk(MCLK),
    .rst_n(RESETN),
    .tick(SUBCLK_TICK),
    .clear(cnt_clear),
    .sel({interval_select_hi, interval_select_lo}),
    .cnt(cnt),
    .tap_fall(tap_fall),
    .stab_wait(stab_wait)
  );

  // ************************************************************
  // tap clock outputs, registered to stay glitch free
  // ************************************************************
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      STAB_WAIT <= 1'b0;
      WDT_CLK <= 1'b0;
      BUZ_CLK <= 3'h0;
    end else begin
      STAB_WAIT <= stab_wait && DUAL_CLOCK;
      WDT_CLK <= cnt[TAP_WDT];
      BUZ_CLK <= cnt[TAP_BUZ_HI:TAP_BUZ_LO];
    end
  end

  // ************************************************************
  // sticky event status, read clears, mask gates irq
  // ************************************************************
  logic [1:0] status;
  logic [1:0] mask;
  logic [1:0] status_set;
  logic status_rd;
  logic stab_done;

  assign stab_done = $bits(stab_done)'(stab_wait && !cnt_clear && SUBCLK_TICK
    && cnt == CNT_ALL_ONES);
  assign status_set = {stab_done, evt};
  assign status_rd = rd_acc && AVS_ADDRESS == ADDR_STATUS;

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      status <= STATUS_RST;
    end else if (status_rd) begin
      // clear only what this read reported; a set at the load edge survives
      status <= (status & ~AVS_READDATA[EVT_W-1:0]) | status_set;
    end else begin
      status <= status | status_set;
    end
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      mask <= MASK_RST;
    end else if (wr_acc && lane0 && AVS_ADDRESS == ADDR_MASK) begin
      mask <= AVS_WRITEDATA[EVT_W-1:0];
    end
  end

  assign EVENT_IRQ = |(status & mask);

  // ************************************************************
  // read data, loaded at the edge that raises the acknowledge
  // ************************************************************
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (AVS_ADDRESS)
      ADDR_CTRL: begin
        next_rdata[CTRL_FLAG] = interval_event_flag;
        next_rdata[CTRL_EN] = interval_irq_enable;
        next_rdata[CTRL_SEL_HI] = interval_select_hi;
        next_rdata[CTRL_SEL_LO] = interval_select_lo;
        next_rdata[CTRL_CLR] = 1'b1;
      end
      ADDR_STATUS: next_rdata[EVT_W-1:0] = status;
      ADDR_MASK: next_rdata[EVT_W-1:0] = mask;
      ADDR_COUNT: begin
        next_rdata[CNT_W-1:0] = cnt;
        next_rdata[COUNT_STAB] = stab_wait;
      end
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      AVS_READDATA <= 32'h0000_0000;
    end else if (AVS_READ && !ack) begin
      AVS_READDATA <= next_rdata;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  chk_sw_clear: assert property (@(posedge MCLK) disable iff (!RESETN)
    sw_clr |=> cnt == CNT_RESET && stab_wait)
    else $error("software clear did not clear counter");
  chk_stop_hold: assert property (@(posedge MCLK) disable iff (!RESETN)
    STOP_REQUEST [*2] |-> cnt == CNT_RESET)
    else $error("counter ran during stop request");
  chk_por_clear: assert property (@(posedge MCLK) disable iff (!RESETN)
    HAS_POR && POWER_ON_CLEAR |=> cnt == CNT_RESET)
    else $error("power-on clear ignored");
  chk_tap_period: assert property (@(posedge MCLK) disable iff (!RESETN)
    evt |=> (cnt & ((15'h0001 << $past(sip_tap_idx({interval_select_hi,
      interval_select_lo}) + 4'h1)) - 15'h0001)) == CNT_RESET)
    else $error("interval event off its period boundary");
  chk_flag_set: assert property (@(posedge MCLK) disable iff (!RESETN)
    evt |=> interval_event_flag)
    else $error("event did not set flag");
  chk_irq_line: assert property (@(posedge MCLK) disable iff (!RESETN)
    evt && interval_irq_enable && !ctrl_wr |=> INTERVAL_IRQ_LINE)
    else $error("enabled event gave no interrupt");
  chk_flag_zero: assert property (@(posedge MCLK) disable iff (!RESETN)
    ctrl_wr && !AVS_WRITEDATA[CTRL_FLAG] && !evt |=> !interval_event_flag)
    else $error("zero write did not clear flag");
  chk_flag_one: assert property (@(posedge MCLK) disable iff (!RESETN)
    ctrl_wr && AVS_WRITEDATA[CTRL_FLAG] && !interval_event_flag && !evt
    |=> !interval_event_flag)
    else $error("one write set the flag");
  chk_clr_reads_one: assert property (@(posedge MCLK) disable iff (!RESETN)
    rd_acc && AVS_ADDRESS == ADDR_CTRL |-> AVS_READDATA[CTRL_CLR])
    else $error("clear bit read as zero");
  chk_coincide: assert property (@(posedge MCLK) disable iff (!RESETN)
    sw_clr && !interval_event_flag |=> !interval_event_flag)
    else $error("flag set on a coincident clear");
  chk_wdt_fall: assert property (@(posedge MCLK) disable iff (!RESETN)
    $fell(WDT_CLK) && !$past(cnt_clear, 2) |-> $past(cnt[13:0]) == 14'h0000)
    else $error("watchdog clock fell off its period");
  chk_buz_rise: assert property (@(posedge MCLK) disable iff (!RESETN)
    $rose(BUZ_CLK[0]) |-> $past(cnt[2:0]) == 3'h4)
    else $error("buzzer clock rose off its period");
  chk_single_clock: assert property (@(posedge MCLK) disable iff (!RESETN)
    !DUAL_CLOCK |-> cnt == CNT_RESET && !evt && !STAB_WAIT)
    else $error("prescaler active in single-clock build");
  chk_bus_wait: assert property (@(posedge MCLK) disable iff (!RESETN)
    req && !ack |=> !AVS_WAITREQUEST || !req)
    else $error("bus answer later than one wait state");

  cov_interval_event: cover property (@(posedge MCLK) disable iff (!RESETN)
    evt && interval_irq_enable);
  cov_clear_coincide: cover property (@(posedge MCLK) disable iff (!RESETN)
    sw_clr && tap_fall);
  cov_stab_done: cover property (@(posedge MCLK) disable iff (!RESETN)
    $fell(STAB_WAIT));
  cov_status_read: cover property (@(posedge MCLK) disable iff (!RESETN)
    status_rd && status != STATUS_RST);

endmodule
`default_nettype wire

// >>> bench/sip_subclk_model.sv
// sub-clock source model: one-cycle tick every gap+1 system clocks
// assumes clk is the prescaler's system clock; no ticks while run is low
`timescale 1ns/1ps
`default_nettype none
module sip_subclk_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [1:0] gap,
  output logic tick
);
  logic [1:0] phase;
  // returns to phase 0 outside a run, so each run starts with a tick
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 2'h0;
      tick <= 1'b0;
    end else begin
      tick <= run && (phase == 2'h0);
      phase <= (!run || phase == gap) ? 2'h0 : phase + 2'h1;
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb_top.sv
// self-checking bench for the sub-clock interval prescaler
// assumes sip_pkg, sip_prescaler and the sub-clock model compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import sip_pkg::*;
;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic stop_req = 1'b0;
  logic por = 1'b0;
  logic rd_s = 1'b0;
  logic wr_s = 1'b0;
  logic run = 1'b0;
  logic [1:0] gap = 2'h0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic [31:0] rd_q;
  logic waitreq, irq_line, evt_irq, stab, wdt, tick;
  logic [2:0] buz;
  logic one_irq, one_evt, one_stab, one_wdt;
  logic [2:0] one_buz;
  logic [31:0] ticks_seen = 32'h0;
  int bad_count = 0;
  int checked = 0;
  int seed = 32'h857d;
  int n;

  // ****************
  // structure
  // ****************
  sip_prescaler #(.HAS_POR(1'b1), .DUAL_CLOCK(1'b1)) dut_u (
    .MCLK(mclk), .RESETN(resetn), .SUBCLK_TICK(tick), .STOP_REQUEST(stop_req),
    .POWER_ON_CLEAR(por), .AVS_ADDRESS(addr), .AVS_READ(rd_s), .AVS_WRITE(wr_s),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata),
    .AVS_WAITREQUEST(waitreq), .INTERVAL_IRQ_LINE(irq_line), .EVENT_IRQ(evt_irq),
    .STAB_WAIT(stab), .WDT_CLK(wdt), .BUZ_CLK(buz));
  sip_subclk_model sub_u (.clk(mclk), .rst_n(resetn), .run(run), .gap(gap), .tick(tick));
  // single-clock build shares the stimulus and must stay silent
  sip_prescaler #(.HAS_POR(1'b1), .DUAL_CLOCK(1'b0)) dut_single_u (
    .MCLK(mclk), .RESETN(resetn), .SUBCLK_TICK(tick), .STOP_REQUEST(stop_req),
    .POWER_ON_CLEAR(por), .AVS_ADDRESS(addr), .AVS_READ(rd_s), .AVS_WRITE(wr_s),
    .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(4'hf), .AVS_READDATA(),
    .AVS_WAITREQUEST(), .INTERVAL_IRQ_LINE(one_irq), .EVENT_IRQ(one_evt),
    .STAB_WAIT(one_stab), .WDT_CLK(one_wdt), .BUZ_CLK(one_buz));

  always #25 mclk = ~mclk;
  // mirror of the counter; any clear wins over a tick
  always @(posedge mclk) begin
    if ((wr_s && addr == ADDR_CTRL && !wdata[CTRL_CLR] && waitreq === 1'b0)
        || stop_req || por) begin
      ticks_seen <= 32'h0;
    end else if (tick === 1'b1) begin
      ticks_seen <= ticks_seen + 32'h1;
    end
  end

  // ****************
  // helpers
  // ****************
  function automatic logic [31:0] exp_ctrl(input logic f, input logic e, input logic [1:0] s);
    exp_ctrl = {24'h0, f, e, 3'h0, s, 1'b1};
  endfunction

  function automatic logic [31:0] exp_period(input logic [1:0] s);
    case (s)
      2'h0: exp_period = 32'h400;
      2'h1: exp_period = 32'h2000;
      2'h2: exp_period = 32'h4000;
      default: exp_period = 32'h8000;
    endcase
  endfunction

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one access; held until the rising edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge mclk);
    addr <= a;
    wdata <= d;
    wr_s <= wr;
    rd_s <= !wr;
    do begin
      @(posedge mclk);
    end while (waitreq !== 1'b0);
    rd_q = rdata;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
  endtask

  task automatic clr(input logic e, input logic [1:0] s);
    bus(1'b1, ADDR_CTRL, {24'h0, 1'b0, e, 3'h0, s, 1'b0});
  endtask

  task report_and_stop;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************
  // scenarios
  // ****************
  initial begin
    repeat (4) @(posedge mclk);
    resetn <= 1'b1;
    @(posedge mclk);
    @(negedge mclk);
    chk("stab_after_reset", 32'h1, stab);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("ctrl_reset", exp_ctrl(CTRL_FLAG_RST, CTRL_EN_RST, CTRL_SEL_RST), rd_q & 32'hc7);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("status_reset", {30'h0, STATUS_RST}, rd_q);
    bus(1'b0, ADDR_MASK, 32'h0);
    chk("mask_reset", {30'h0, MASK_RST}, rd_q);
    bus(1'b0, 4'h2, 32'h0);
    chk("unmapped_read", 32'h0, rd_q);
    bus(1'b1, ADDR_MASK, 32'h1);
    for (int s = 0; s < 4; s++) begin
      clr(s[0], s[1:0]);
      run <= 1'b1;
      n = 0;
      while (evt_irq !== 1'b1 && n < 40000) begin
        @(negedge mclk);
        n++;
      end
      if (n >= 40000) bad_count++;
      chk("interval_ticks", exp_period(s[1:0]), ticks_seen);
      chk("irq_line_enable", s[0], irq_line);
      @(posedge mclk);
      run <= 1'b0;
      repeat (3) @(posedge mclk);
      chk("stab_wait", s != 3, stab);
      chk("wdt_clk", ticks_seen[13], wdt);
      chk("buz_clk", ticks_seen[4:2], buz);
      bus(1'b0, ADDR_STATUS, 32'h0);
      chk("status_events", (s == 3) ? 32'h3 : 32'h1, rd_q);
      @(negedge mclk);
      chk("event_irq_cleared", 32'h0, evt_irq);
    end
    bus(1'b0, ADDR_COUNT, 32'h0);
    chk("count_wrap", ticks_seen & 32'h7fff, rd_q & 32'h17fff);
    bus(1'b1, ADDR_CTRL, exp_ctrl(1'b1, 1'b1, 2'h3));
    @(negedge mclk);
    chk("flag_write_one", 32'h1, irq_line);
    bus(1'b0, ADDR_COUNT, 32'h0);
    chk("clear_write_one", ticks_seen & 32'h7fff, rd_q & 32'h7fff);
    bus(1'b1, ADDR_CTRL, exp_ctrl(1'b0, 1'b1, 2'h3));
    @(negedge mclk);
    chk("flag_write_zero", 32'h0, irq_line);
    // 1022 idle edges plus three bus edges: accept lands on tick 1024
    clr(1'b0, 2'h0);
    run <= 1'b1;
    repeat (1022) @(posedge mclk);
    clr(1'b0, 2'h0);
    run <= 1'b0;
    repeat (3) @(posedge mclk);
    bus(1'b0, ADDR_STATUS, 32'h0);
    chk("coincide_status", 32'h0, rd_q);
    bus(1'b0, ADDR_CTRL, 32'h0);
    chk("coincide_flag", 32'h0, rd_q & 32'h80);
    for (int i = 0; i < 3; i++) begin
      clr(1'b0, 2'h0);
      gap <= 2'($random(seed));
      run <= 1'b1;
      repeat (100 + ($unsigned($random(seed)) % 600)) @(posedge mclk);
      run <= 1'b0;
      repeat (4) @(posedge mclk);
      bus(1'b0, ADDR_COUNT, 32'h0);
      chk("count", ticks_seen & 32'h7fff, rd_q & 32'h7fff);
      chk("buz_clk_rand", ticks_seen[4:2], buz);
      chk("single_clock_quiet", 32'h0, {26'h0, one_irq, one_evt, one_stab, one_wdt, one_buz});
    end
    for (int i = 0; i < 2; i++) begin
      run <= 1'b1;
      repeat (50) @(posedge mclk);
      stop_req <= (i == 0);
      por <= (i == 1);
      run <= 1'b0;
      repeat (3) @(posedge mclk);
      stop_req <= 1'b0;
      por <= 1'b0;
      repeat (4) @(posedge mclk);
      bus(1'b0, ADDR_COUNT, 32'h0);
      chk("count_held_clear", 32'h10000, rd_q & 32'h17fff);
    end
    report_and_stop;
  end

  // about 61k cycles expected; this cuts a hang short
  initial begin
    repeat (90000) @(posedge mclk);
    bad_count++;
    report_and_stop;
  end
endmodule
`default_nettype wire
